// ### logic/dfcr_pkg.sv
/*
 * constants and types shared by the drive fault class responder.
 * assumes a single drive clock; included by package-qualified names only.
 */
`default_nettype none
package dfcr_pkg;
    // ==========================================================
    // object addresses (class, instance, attribute)
    localparam logic [7:0]  OBJ_ERR_CLS   = 8'h64;
    localparam logic [7:0]  OBJ_ERR_INST  = 8'h01;
    localparam logic [7:0]  OBJ_ERR_ATTR  = 8'h01;
    localparam logic [7:0]  OBJ_RT_CLS    = 8'h7D;
    localparam logic [7:0]  OBJ_RT_INST   = 8'h01;
    localparam logic [7:0]  OBJ_RT_ATTR   = 8'h06;
    localparam logic [7:0]  OBJ_CMD_CLS   = 8'h7E;
    localparam logic [7:0]  OBJ_CMD_INST  = 8'h01;
    localparam logic [7:0]  OBJ_CMD_ATTR  = 8'h01;
    localparam logic [15:0] RT_MODBUS_ADR = 16'h190C;
    // ==========================================================
    // register values
    localparam logic [15:0] RT_CLASS_RST  = 16'h0000;
    localparam logic [15:0] RT_CLASS_MAX  = 16'h0001;
    // ==========================================================
    // reply codes
    localparam logic [7:0]  GEN_OK        = 8'h00;
    localparam logic [7:0]  GEN_VENDOR    = 8'h1F;
    localparam logic [15:0] E_RANGE       = 16'h1100;
    localparam logic [15:0] E_NO_INDEX    = 16'h1101;
    localparam logic [15:0] E_NO_SUBIDX   = 16'h1102;
    localparam logic [15:0] E_READ_ONLY   = 16'h1103;
    localparam logic [15:0] E_NO_EXPERT   = 16'h1104;
    localparam logic [15:0] E_PWR_ACTIVE  = 16'h1106;
    localparam logic [15:0] E_RT_DATA     = 16'h8100;
    // ==========================================================
    // classes and fields
    localparam logic [2:0]  CLS0          = 3'h0;
    localparam logic [2:0]  CLS1          = 3'h1;
    localparam logic [2:0]  CLS2          = 3'h2;
    localparam logic [2:0]  CLS3          = 3'h3;
    localparam logic [2:0]  CLS4          = 3'h4;
    localparam int          MODE_ERR_BIT  = 6;
    localparam int          CAT_MSB       = 15;
    localparam int          CAT_LSB       = 12;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HALT,
        ST_STOP_WAIT,
        ST_SETTLE,
        ST_OFF
    } dfcr_state_e;
endpackage
`default_nettype wire

// ### logic/dfcr_param_access.sv
/*
 * explicit-message parameter access: decode, checks, reply codes,
 * and the realtime data fault class register.
 * assumes one request per cycle at most, from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dfcr_param_access (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [7:0]  req_class,
    input  wire logic [7:0]  req_inst,
    input  wire logic [7:0]  req_attr,
    input  wire logic [15:0] req_data,
    input  wire logic        expert_auth,
    input  wire logic        power_enabled,
    input  wire logic [15:0] last_err_code,
    output logic             resp_valid,
    output logic [7:0]       resp_general,
    output logic [7:0]       resp_additional,
    output logic [15:0]      resp_data,
    output logic             perr_valid,
    output logic [15:0]      perr_code,
    output logic [15:0]      rt_class
);
    logic        rv_d, rv_q, pe_d, pe_q;
    logic [7:0]  gen_d, gen_q, add_d, add_q;
    logic [15:0] dat_d, dat_q, code_d, code_q, rt_d, rt_q;
    logic        hit_err, hit_rt, hit_cmd, fail;
    logic [15:0] ecode;

    // ==========================================================
    // decode and checks
    always_comb begin
        hit_err = (req_inst == dfcr_pkg::OBJ_ERR_INST) && (req_attr == dfcr_pkg::OBJ_ERR_ATTR);
        hit_rt  = (req_inst == dfcr_pkg::OBJ_RT_INST) && (req_attr == dfcr_pkg::OBJ_RT_ATTR);
        hit_cmd = (req_inst == dfcr_pkg::OBJ_CMD_INST) && (req_attr == dfcr_pkg::OBJ_CMD_ATTR);
        fail    = 1'b1;
        ecode   = dfcr_pkg::E_NO_INDEX; // RQ14
        dat_d   = 16'h0000;
        rt_d    = rt_q;
        case (req_class)
            dfcr_pkg::OBJ_ERR_CLS: begin
                if (!hit_err) begin
                    ecode = dfcr_pkg::E_NO_SUBIDX; // RQ14
                end else if (req_write) begin
                    ecode = dfcr_pkg::E_READ_ONLY; // RQ15
                end else begin
                    fail  = 1'b0;
                    dat_d = last_err_code; // RQ4
                end
            end
            dfcr_pkg::OBJ_RT_CLS: begin
                if (!hit_rt) begin
                    ecode = dfcr_pkg::E_NO_SUBIDX; // RQ14
                end else if (req_write && req_data > dfcr_pkg::RT_CLASS_MAX) begin
                    ecode = dfcr_pkg::E_RANGE; // RQ14
                end else begin
                    fail  = 1'b0;
                    dat_d = rt_q;
                    if (req_write) begin
                        rt_d = req_data; // RQ1
                    end
                end
            end
            dfcr_pkg::OBJ_CMD_CLS: begin
                if (!hit_cmd) begin
                    ecode = dfcr_pkg::E_NO_SUBIDX; // RQ14
                end else if (req_write && !expert_auth) begin
                    ecode = dfcr_pkg::E_NO_EXPERT; // RQ16
                end else if (req_write && power_enabled) begin
                    ecode = dfcr_pkg::E_PWR_ACTIVE; // RQ17
                end else begin
                    fail = 1'b0;
                    if (req_write) begin
                        rt_d = dfcr_pkg::RT_CLASS_RST;
                    end
                end
            end
            default: begin
                fail = 1'b1;
            end
        endcase
        if (!req_valid) begin
            rt_d = rt_q;
        end
        rv_d   = req_valid;
        pe_d   = req_valid && fail;
        code_d = fail ? ecode : code_q;
        gen_d  = fail ? dfcr_pkg::GEN_VENDOR : dfcr_pkg::GEN_OK; // RQ2
        add_d  = fail ? ecode[7:0] : 8'h00; // RQ3
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rv_q   <= 1'b0;
            pe_q   <= 1'b0;
            gen_q  <= 8'h00;
            add_q  <= 8'h00;
            dat_q  <= 16'h0000;
            code_q <= 16'h0000;
            rt_q   <= dfcr_pkg::RT_CLASS_RST;
        end else begin
            rv_q   <= rv_d;
            pe_q   <= pe_d;
            gen_q  <= req_valid ? gen_d : gen_q;
            add_q  <= req_valid ? add_d : add_q;
            dat_q  <= req_valid ? dat_d : dat_q;
            code_q <= code_d;
            rt_q   <= rt_d;
        end
    end

    assign resp_valid      = rv_q;
    assign resp_general    = gen_q;
    assign resp_additional = add_q;
    assign resp_data       = dat_q;
    assign perr_valid      = pe_q;
    assign perr_code       = code_q;
    assign rt_class        = rt_q;
endmodule // dfcr_param_access
`default_nettype wire

// ### logic/dfcr_io_status.sv
/*
 * cyclic i/o reply: mode status byte with the mode error flag.
 * assumes command strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dfcr_io_status (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_bad,
    input  wire logic [7:0] mode_bits,
    output logic            resp_valid,
    output logic [7:0]      mode_status_byte,
    output logic            bad_event
);
    logic       me_d, me_q, rv_d, rv_q, be_d, be_q;
    logic [7:0] msb_d, msb_q;

    // ==========================================================
    // flag follows each command; a good one clears it
    always_comb begin
        me_d  = cmd_valid ? cmd_bad : me_q; // RQ5 RQ6
        rv_d  = cmd_valid;
        be_d  = cmd_valid && cmd_bad; // RQ5
        msb_d = msb_q;
        if (cmd_valid) begin
            msb_d = mode_bits;
            msb_d[dfcr_pkg::MODE_ERR_BIT] = cmd_bad; // RQ5
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            me_q  <= 1'b0;
            rv_q  <= 1'b0;
            be_q  <= 1'b0;
            msb_q <= 8'h00;
        end else begin
            me_q  <= me_d;
            rv_q  <= rv_d;
            be_q  <= be_d;
            msb_q <= msb_d;
        end
    end

    assign resp_valid       = rv_q;
    assign mode_status_byte = msb_q;
    assign bad_event        = be_q;
endmodule // dfcr_io_status
`default_nettype wire

// ### logic/dfcr_responder.sv
/*
 * drive fault class responder: collects error events, latches the
 * newest code, holds the active class and drives the reaction.
 * assumes the operating-state machine outside acts on the transition
 * pulses and reports power stage enable and motor standstill.
 */
// Contract
// RQ1: rt data fault class selectable, immediate
// RQ2: failed explicit request replies two codes
// RQ3: general 1F carries vendor coded number
// RQ4: error number readable at object 100.1.1
// RQ5: bad io command sets mode error bit
// RQ6: next valid transmission clears mode error
// RQ7: detected error gets code and class
// RQ8: leading hex digit gives error category
// RQ9: class 0 keeps motion, no transition
// RQ10: class 1 rapid halt via halt transition
// RQ11: class 2 halt, then power off standstill
// RQ12: class 3/4 power off immediately
// RQ13: fault clear ends 0-3; class 4 sticks
// RQ14: range, index, subindex faults flag class 0
// RQ15: read-only write refused, E 1103
// RQ16: expert write without authorization refused
// RQ17: commands refused while power stage enabled
// RQ18: newest error code latched for reading
`timescale 1ns/1ps
`default_nettype none
module dfcr_responder #(
    parameter logic [15:0] RT_ERR_CODE = dfcr_pkg::E_RT_DATA
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        exp_req_valid,
    input  wire logic        exp_req_write,
    input  wire logic [7:0]  exp_req_class,
    input  wire logic [7:0]  exp_req_inst,
    input  wire logic [7:0]  exp_req_attr,
    input  wire logic [15:0] exp_req_data,
    input  wire logic        exp_expert_auth,
    output logic             exp_resp_valid,
    output logic [7:0]       exp_resp_general,
    output logic [7:0]       exp_resp_additional,
    output logic [15:0]      exp_resp_data,
    input  wire logic        io_cmd_valid,
    input  wire logic        io_cmd_bad,
    input  wire logic [7:0]  io_mode_bits,
    output logic             io_resp_valid,
    output logic [7:0]       mode_status_byte,
    input  wire logic        mon_err_valid,
    input  wire logic [15:0] mon_err_code,
    input  wire logic [2:0]  mon_err_class,
    input  wire logic        fault_clear,
    input  wire logic        motor_standstill,
    input  wire logic        power_stage_enabled,
    output logic             err_active,
    output logic [15:0]      err_code,
    output logic [2:0]       err_class,
    output logic [3:0]       err_category,
    output logic             quick_stop_req,
    output logic             power_disable_req,
    output logic             halt_transition,
    output logic             fault_entry_transition,
    output logic             fault_settle_transition,
    output logic [15:0]      realtime_data_fault_class
);
    // ==========================================================
    // sub-blocks
    logic        perr_valid;
    logic [15:0] perr_code;
    logic        io_bad_event;
    logic [15:0] rt_class;
    logic [15:0] code_q, code_d;

    dfcr_param_access u_param (
        .clock          (clock),
        .rst            (rst),
        .req_valid      (exp_req_valid),
        .req_write      (exp_req_write),
        .req_class      (exp_req_class),
        .req_inst       (exp_req_inst),
        .req_attr       (exp_req_attr),
        .req_data       (exp_req_data),
        .expert_auth    (exp_expert_auth),
        .power_enabled  (power_stage_enabled),
        .last_err_code  (code_q),
        .resp_valid     (exp_resp_valid),
        .resp_general   (exp_resp_general),
        .resp_additional(exp_resp_additional),
        .resp_data      (exp_resp_data),
        .perr_valid     (perr_valid),
        .perr_code      (perr_code),
        .rt_class       (rt_class)
    );

    dfcr_io_status u_io (
        .clock           (clock),
        .rst             (rst),
        .cmd_valid       (io_cmd_valid),
        .cmd_bad         (io_cmd_bad),
        .mode_bits       (io_mode_bits),
        .resp_valid      (io_resp_valid),
        .mode_status_byte(mode_status_byte),
        .bad_event       (io_bad_event)
    );

    // ==========================================================
    // event selection: monitor beats realtime data beats parameters
    logic        evt;
    logic [15:0] evt_code;
    logic [2:0]  evt_class;
    logic [2:0]  rt_evt_class;

    always_comb begin
        // only bit 0 of the setting matters, range check keeps it 0 or 1
        rt_evt_class = rt_class[0] ? dfcr_pkg::CLS1 : dfcr_pkg::CLS0; // RQ1
        evt       = 1'b1;
        evt_code  = mon_err_code;
        evt_class = mon_err_class; // RQ7
        if (mon_err_valid) begin
            evt_code  = mon_err_code;
            evt_class = (mon_err_class > dfcr_pkg::CLS4) ? dfcr_pkg::CLS4 : mon_err_class;
        end else if (io_bad_event) begin
            evt_code  = RT_ERR_CODE;
            evt_class = rt_evt_class; // RQ1
        end else if (perr_valid) begin
            evt_code  = perr_code;
            evt_class = dfcr_pkg::CLS0; // RQ14
        end else begin
            evt = 1'b0;
        end
    end

    // ==========================================================
    // error record: newest code, worst active class
    logic       act_q, act_d;
    logic [2:0] cls_q, cls_d;

    always_comb begin
        code_d = code_q;
        cls_d  = cls_q;
        act_d  = act_q;
        // clear first so that an event in the same cycle survives it
        if (fault_clear && cls_q != dfcr_pkg::CLS4) begin
            act_d = 1'b0; // RQ13
            cls_d = dfcr_pkg::CLS0;
        end
        if (evt) begin
            code_d = evt_code; // RQ18
            act_d  = 1'b1; // RQ7
            if (!act_d || evt_class > cls_d) begin
                cls_d = evt_class;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            code_q <= 16'h0000;
            cls_q  <= dfcr_pkg::CLS0;
            act_q  <= 1'b0;
        end else begin
            code_q <= code_d;
            cls_q  <= cls_d;
            act_q  <= act_d;
        end
    end

    // ==========================================================
    // reaction state machine
    // outputs are registered from the next state, so the state machine outside sees clean pulses
    dfcr_pkg::dfcr_state_e st_q, st_d;
    logic                  qs_q, qs_d, pd_q, pd_d, ht_q, ht_d, fe_q, fe_d, fs_q, fs_d;

    always_comb begin
        st_d = st_q;
        case (st_q)
            dfcr_pkg::ST_IDLE: begin
                // class 0 stays here: motion untouched, no transition
                if (act_q && cls_q >= dfcr_pkg::CLS3) begin
                    st_d = dfcr_pkg::ST_SETTLE; // RQ12
                end else if (act_q && cls_q == dfcr_pkg::CLS2) begin
                    st_d = dfcr_pkg::ST_STOP_WAIT; // RQ11
                end else if (act_q && cls_q == dfcr_pkg::CLS1) begin
                    st_d = dfcr_pkg::ST_HALT; // RQ10
                end else begin
                    st_d = dfcr_pkg::ST_IDLE; // RQ9
                end
            end
            dfcr_pkg::ST_HALT: begin
                if (!act_q) begin
                    st_d = dfcr_pkg::ST_IDLE; // RQ13
                end else if (cls_q >= dfcr_pkg::CLS2) begin
                    st_d = dfcr_pkg::ST_STOP_WAIT;
                end
            end
            dfcr_pkg::ST_STOP_WAIT: begin
                if (!act_q) begin
                    st_d = dfcr_pkg::ST_IDLE; // RQ13
                end else if (cls_q >= dfcr_pkg::CLS3 || motor_standstill) begin
                    st_d = dfcr_pkg::ST_SETTLE; // RQ11
                end
            end
            dfcr_pkg::ST_SETTLE: begin
                st_d = dfcr_pkg::ST_OFF;
            end
            dfcr_pkg::ST_OFF: begin
                // class 4 never drops act_q, so after a class 4 error only a reset leaves here; a cleared class 3 returns to idle
                if (!act_q) begin
                    st_d = dfcr_pkg::ST_IDLE; // RQ13
                end
            end
            default: begin
                st_d = dfcr_pkg::ST_IDLE;
            end
        endcase
        qs_d = (st_d == dfcr_pkg::ST_HALT) || (st_d == dfcr_pkg::ST_STOP_WAIT); // RQ10 RQ11
        pd_d = (st_d == dfcr_pkg::ST_SETTLE) || (st_d == dfcr_pkg::ST_OFF); // RQ11 RQ12
        ht_d = (st_d == dfcr_pkg::ST_HALT) && (st_q != dfcr_pkg::ST_HALT); // RQ10
        fe_d = ((st_d == dfcr_pkg::ST_STOP_WAIT) || (st_d == dfcr_pkg::ST_SETTLE))
               && ((st_q == dfcr_pkg::ST_IDLE) || (st_q == dfcr_pkg::ST_HALT)); // RQ11 RQ12
        fs_d = (st_d == dfcr_pkg::ST_SETTLE); // RQ11 RQ12
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= dfcr_pkg::ST_IDLE;
            {qs_q, pd_q, ht_q, fe_q, fs_q} <= 5'h00;
        end else begin
            st_q <= st_d;
            {qs_q, pd_q, ht_q, fe_q, fs_q} <= {qs_d, pd_d, ht_d, fe_d, fs_d};
        end
    end

    assign err_active                = act_q;
    assign err_code                  = code_q;
    assign err_class                 = cls_q;
    assign err_category              = code_q[dfcr_pkg::CAT_MSB:dfcr_pkg::CAT_LSB]; // RQ8
    assign quick_stop_req            = qs_q;
    assign power_disable_req         = pd_q;
    assign halt_transition           = ht_q;
    assign fault_entry_transition    = fe_q;
    assign fault_settle_transition   = fs_q;
    assign realtime_data_fault_class = rt_class;
endmodule // dfcr_responder
`default_nettype wire

// ### bench/dfcr_properties.sv
/*
 * checker for the drive fault class responder, bound to its top module.
 * assumes one clock and a synchronous active-high reset on the block.
 */
`timescale 1ns/1ps
`default_nettype none
module dfcr_properties (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        io_cmd_valid,
    input wire logic        io_cmd_bad,
    input wire logic        io_resp_valid,
    input wire logic [7:0]  mode_status_byte,
    input wire logic        mon_err_valid,
    input wire logic [2:0]  mon_err_class,
    input wire logic        fault_clear,
    input wire logic        motor_standstill,
    input wire logic        err_active,
    input wire logic [15:0] err_code,
    input wire logic [2:0]  err_class,
    input wire logic [3:0]  err_category,
    input wire logic        quick_stop_req,
    input wire logic        power_disable_req,
    input wire logic        halt_transition,
    input wire logic [15:0] realtime_data_fault_class
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ==========================================================
    // relations; four-cycle windows cover any reply latency
    rt_class_range_a: assert property (realtime_data_fault_class <= 16'h0001)
        else $error("realtime fault class out of range");
    mode_err_set_a: assert property (io_cmd_valid && io_cmd_bad |-> ##[1:4] (io_resp_valid && mode_status_byte[6]))
        else $error("mode error flag not set");
    mode_err_clear_a: assert property (io_cmd_valid && !io_cmd_bad |-> ##[1:4] (io_resp_valid && !mode_status_byte[6]))
        else $error("mode error flag not cleared");
    cat_digit_a: assert property (err_active |-> err_category == err_code[15:12])
        else $error("category is not the leading digit");
    class0_quiet_a: assert property (mon_err_valid && mon_err_class == 3'h0 && !err_active
        |=> (!halt_transition && !quick_stop_req && !power_disable_req)[*4])
        else $error("class 0 error disturbed motion");
    class1_halt_a: assert property (mon_err_valid && mon_err_class == 3'h1 && !err_active |-> ##[1:4] halt_transition)
        else $error("class 1 error gave no halt");
    standstill_off_a: assert property (err_active && err_class == 3'h2 && motor_standstill |-> ##[0:4] power_disable_req)
        else $error("class 2 standstill kept power on");
    high_class_off_a: assert property (mon_err_valid && mon_err_class >= 3'h3 && !err_active
        |-> ##[1:4] power_disable_req)
        else $error("class 3 or 4 error kept power on");
    class4_sticks_a: assert property (err_active && err_class == 3'h4 |=> err_active)
        else $error("class 4 error was cleared");
    fault_clear_a: assert property (fault_clear && err_active && err_class != 3'h4 && !mon_err_valid
        |-> ##[1:4] !err_active)
        else $error("fault clear left error active");
endmodule // dfcr_properties
bind dfcr_responder dfcr_properties u_props (.*);
`default_nettype wire

// ### bench/dfcr_master.sv
/*
 * fieldbus master model: explicit requests and cyclic i/o commands.
 * assumes each request is taken on one edge and answered by a valid strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module dfcr_master (
    input  wire logic  clock,
    input  wire logic  exp_resp_valid,
    input  wire logic  io_resp_valid,
    output logic       exp_req_valid,
    output logic       exp_req_write,
    output logic [7:0] exp_req_class,
    output logic [7:0] exp_req_inst,
    output logic [7:0] exp_req_attr,
    output logic [15:0] exp_req_data,
    output logic       io_cmd_valid,
    output logic       io_cmd_bad,
    output logic [7:0] io_mode_bits
);
    // ==========================================================
    // released lines show the inverse of their last value, not a stale copy
    initial begin
        {exp_req_valid, exp_req_write, exp_req_class, exp_req_inst, exp_req_attr, exp_req_data} = '0;
        {io_cmd_valid, io_cmd_bad} = 2'h0;
        io_mode_bits = 8'h05;
    end
    // ==========================================================
    // transfers; also used to read back the error number object
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] i, input logic [7:0] a,
                        input logic [15:0] d);
        {exp_req_valid, exp_req_write, exp_req_class, exp_req_inst, exp_req_attr, exp_req_data} = {1'b1, w, c, i, a, d};
        @(posedge clock);
        #1;
        exp_req_valid = 1'b0;
        {exp_req_write, exp_req_class, exp_req_inst, exp_req_attr, exp_req_data} = ~{w, c, i, a, d};
        repeat (8) if (exp_resp_valid !== 1'b1) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic io(input logic b);
        {io_cmd_valid, io_cmd_bad} = {1'b1, b};
        @(posedge clock);
        #1;
        {io_cmd_valid, io_cmd_bad} = {1'b0, ~b};
        repeat (8) if (io_resp_valid !== 1'b1) begin
            @(posedge clock);
            #1;
        end
    endtask
endmodule // dfcr_master
`default_nettype wire

// ### bench/testbench.sv
/*
 * self-checking bench for the drive fault class responder.
 * assumes the master model drives the fieldbus side and the bench the rest.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, rst, exp_req_valid, exp_req_write, exp_expert_auth, exp_resp_valid, io_cmd_valid;
    logic [7:0]  exp_req_class, exp_req_inst, exp_req_attr, exp_resp_general, exp_resp_additional, io_mode_bits;
    logic [15:0] exp_req_data, exp_resp_data, mon_err_code, err_code, realtime_data_fault_class;
    logic        io_cmd_bad, io_resp_valid, mon_err_valid, fault_clear, motor_standstill, power_stage_enabled;
    logic        err_active, quick_stop_req, power_disable_req, halt_transition;
    logic        fault_entry_transition, fault_settle_transition;
    logic [7:0]  mode_status_byte;
    logic [2:0]  mon_err_class, err_class;
    logic [3:0]  err_category;
    int          fails, checks;
    logic [15:0] codes [5] = '{16'h4101, 16'hA300, 16'h3202, 16'h2300, 16'h1301};

    dfcr_responder u_dut (.*);
    dfcr_master u_master (.*);
    always #2.5 clock = ~clock;
    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic ex(input logic w, input logic [7:0] c, input logic [7:0] i, input logic [7:0] a,
                      input logic [15:0] d, input logic [7:0] gen);
        u_master.xfer(w, c, i, a, d);
        chk(16'(exp_resp_valid), 16'h0001);
        chk(16'(exp_resp_general), 16'(gen));
        cyc(2);
    endtask
    task automatic clear_fault();
        fault_clear = 1'b1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(4);
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        {clock, rst, exp_expert_auth, mon_err_valid, fault_clear, motor_standstill, power_stage_enabled} = 7'h30;
        {mon_err_class, mon_err_code} = '0;
        repeat (6) @(posedge clock);
        #1;
        rst = 1'b0;
        ex(1'b0, dfcr_pkg::OBJ_RT_CLS, dfcr_pkg::OBJ_RT_INST, dfcr_pkg::OBJ_RT_ATTR, 16'h0000, dfcr_pkg::GEN_OK);
        chk(exp_resp_data, dfcr_pkg::RT_CLASS_RST);
        ex(1'b1, dfcr_pkg::OBJ_RT_CLS, dfcr_pkg::OBJ_RT_INST, dfcr_pkg::OBJ_RT_ATTR, 16'h0001, dfcr_pkg::GEN_OK);
        chk(realtime_data_fault_class, 16'h0001);
        ex(1'b1, dfcr_pkg::OBJ_RT_CLS, dfcr_pkg::OBJ_RT_INST, dfcr_pkg::OBJ_RT_ATTR, 16'h0002, dfcr_pkg::GEN_VENDOR);
        chk(err_code, dfcr_pkg::E_RANGE);
        chk(realtime_data_fault_class, 16'h0001);
        ex(1'b1, dfcr_pkg::OBJ_ERR_CLS, dfcr_pkg::OBJ_ERR_INST, dfcr_pkg::OBJ_ERR_ATTR, 16'h0000, dfcr_pkg::GEN_VENDOR);
        chk(err_code, dfcr_pkg::E_READ_ONLY);
        ex(1'b0, 8'h55, dfcr_pkg::OBJ_RT_INST, dfcr_pkg::OBJ_RT_ATTR, 16'h0000, dfcr_pkg::GEN_VENDOR);
        chk(err_code, dfcr_pkg::E_NO_INDEX);
        ex(1'b0, dfcr_pkg::OBJ_RT_CLS, dfcr_pkg::OBJ_RT_INST, 8'h09, 16'h0000, dfcr_pkg::GEN_VENDOR);
        chk(err_code, dfcr_pkg::E_NO_SUBIDX);
        ex(1'b0, dfcr_pkg::OBJ_ERR_CLS, dfcr_pkg::OBJ_ERR_INST, dfcr_pkg::OBJ_ERR_ATTR, 16'h0000, dfcr_pkg::GEN_OK);
        chk(exp_resp_data, dfcr_pkg::E_NO_SUBIDX);
        power_stage_enabled = 1'b1;
        ex(1'b1, dfcr_pkg::OBJ_CMD_CLS, dfcr_pkg::OBJ_CMD_INST, dfcr_pkg::OBJ_CMD_ATTR, 16'h0001, dfcr_pkg::GEN_VENDOR);
        chk(err_code, dfcr_pkg::E_PWR_ACTIVE);
        chk(16'(err_class), 16'(dfcr_pkg::CLS0));
        power_stage_enabled = 1'b0;
        clear_fault();
        chk(16'(err_active), 16'h0000);
        $display("test explicit done");
        u_master.io(1'b1);
        chk(16'(mode_status_byte[dfcr_pkg::MODE_ERR_BIT]), 16'h0001);
        cyc(1);
        chk(err_code, dfcr_pkg::E_RT_DATA);
        chk(16'(err_class), 16'(dfcr_pkg::CLS1));
        u_master.io(1'b0);
        chk(16'(mode_status_byte[dfcr_pkg::MODE_ERR_BIT]), 16'h0000);
        clear_fault();
        chk(16'(err_active), 16'h0000);
        $display("test cyclic done");
        for (int c = 0; c < 5; c++) begin
            {mon_err_valid, mon_err_class, mon_err_code} = {1'b1, 3'(c), codes[c]};
            cyc(1);
            mon_err_valid = 1'b0;
            cyc(4);
            chk(err_code, codes[c]);
            chk(16'(err_class), 16'(c));
            chk(16'(err_category), 16'(codes[c][15:12]));
            chk(16'(quick_stop_req), 16'(c == 1 || c == 2));
            chk(16'(power_disable_req), 16'(c > 2));
            motor_standstill = 1'b1;
            cyc(4);
            chk(16'(power_disable_req), 16'(c > 1));
            clear_fault();
            chk(16'(err_active), 16'(c == 4));
            motor_standstill = 1'b0;
        end
        $display("test classes done");
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
        cyc(1);
        chk(realtime_data_fault_class, dfcr_pkg::RT_CLASS_RST);
        chk(16'(err_active), 16'h0000);
        $display("test power cycle done");
        close_out();
    end
    initial begin
        #20000;
        fails++;
        $display("watchdog expired");
        close_out();
    end
endmodule // testbench
`default_nettype wire
